// [shared/cswgp_pkg.sv]
// package: constants and types for chip-select wake and pin configuration
package cswgp_pkg;
    localparam int  PIN_COUNT          = 6;
    localparam int  HV_PIN_COUNT       = 4;
    localparam int  CLK_SYS_KHZ        = 25000;
    localparam int  DEBOUNCE_MAX_US    = 256;
    localparam int  DEBOUNCE_MAX_CYC   = (DEBOUNCE_MAX_US * CLK_SYS_KHZ) / 1000;
    localparam int  DEB_W              = 13;

    // pin output modes
    localparam logic [1:0] OUT_NONE      = 2'h0;
    localparam logic [1:0] OUT_OD_LOW    = 2'h1;
    localparam logic [1:0] OUT_PUSH_PULL = 2'h2;
    localparam logic [1:0] OUT_OD_HIGH   = 2'h3;

    // high-voltage input modes
    localparam logic [1:0] plain_input_mode           = 2'h0;
    localparam logic [1:0] schmitt_input_mode         = 2'h1;
    localparam logic [1:0] low_level_input_mode       = 2'h2;
    localparam logic [1:0] ultra_low_level_input_mode = 2'h3;

    localparam logic       LEVEL_1V2 = 1'b0;
    localparam logic       LEVEL_1V8 = 1'b1;

    // per-pin configuration word
    typedef struct packed {
        logic [1:0] out_mode;
        logic [1:0] in_mode;
        logic       pull_down;
        logic       out_value;
        logic       alt_func;
    } cswgp_pin_cfg_t;

    localparam cswgp_pin_cfg_t CFG_RESET_HV = '{OUT_NONE, plain_input_mode, 1'b1, 1'b0, 1'b0};
    localparam cswgp_pin_cfg_t CFG_RESET_LV = '{OUT_NONE, plain_input_mode, 1'b0, 1'b0, 1'b0};

    // events that clear the integrity flag
    typedef struct packed {
        logic uvlo;
        logic por;
        logic over_temp;
        logic seq_crash;
        logic sw_reset;
    } cswgp_reset_events_t;

    typedef enum logic [2:0] {
        ST_LOW_IQ = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_DEBNC  = 3'b100
    } cswgp_state_t;
endpackage

// [rtl/cswgp_pin_cell.sv]
// single pin cell: output drive and enable from its own configuration
`timescale 1ns/1ns
module cswgp_pin_cell #(
    parameter bit HIGH_VOLTAGE = 1'b1,
    parameter bit OUTPUT_ALLOWED = 1'b1
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire cswgp_pkg::cswgp_pin_cfg_t cfg,
    input  wire logic                     pin_in,
    output logic                          pin_out,
    output logic                          pin_oe,
    output logic                          pin_value
);
    logic sync_a;
    logic sync_b;
    logic next_out;
    logic next_oe;

    always_comb begin
        next_out = 1'b0;
        next_oe  = 1'b0;
        if (OUTPUT_ALLOWED) begin
            unique case (cfg.out_mode)
                cswgp_pkg::OUT_NONE: begin
                    next_oe = 1'b0;
                end
                cswgp_pkg::OUT_OD_LOW: begin
                    next_out = 1'b0;
                    next_oe  = ~cfg.out_value;
                end
                cswgp_pkg::OUT_PUSH_PULL: begin
                    next_out = cfg.out_value;
                    next_oe  = HIGH_VOLTAGE;
                end
                cswgp_pkg::OUT_OD_HIGH: begin
                    next_out = 1'b1;
                    next_oe  = HIGH_VOLTAGE & cfg.out_value;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_a  <= 1'b0;
            sync_b  <= 1'b0;
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            sync_a  <= pin_in;
            sync_b  <= sync_a;
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

    assign pin_value = sync_b;
endmodule

// [rtl/cswgp_top.sv]
// top: chip-select wake, shutdown debounce, integrity flag and pin configuration
`timescale 1ns/1ns
module cswgp_top #(
    parameter int PINS = cswgp_pkg::PIN_COUNT
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          chip_select,
    input  wire logic [cswgp_pkg::DEB_W-1:0]   select_release_debounce_time,
    input  wire cswgp_pkg::cswgp_reset_events_t reset_events,
    input  wire logic                          flag_set,
    input  wire logic                          cfg_write,
    input  wire logic [2:0]                    cfg_index,
    input  wire cswgp_pkg::cswgp_pin_cfg_t     cfg_data,
    input  wire logic                          lv_level_write,
    input  wire logic                          lv_level_data,
    input  wire logic                          i2c_data_pull_low,
    input  wire logic [PINS-1:0]               pin_in,
    output logic      [PINS-1:0]               pin_out,
    output logic      [PINS-1:0]               pin_oe,
    output logic      [PINS-1:0]               pin_pull_down,
    output logic      [1:0]                    hv_input_mode [cswgp_pkg::HV_PIN_COUNT],
    output logic                               lv_input_level,
    output logic      [PINS-1:0]               pin_value,
    output logic                               awake,
    output logic                               logic_shutdown,
    output logic                               config_integrity_flag,
    output logic      [3:0]                    target_addr_bits,
    output logic                               i2c_data_in,
    output logic                               i2c_clock_in
);
    cswgp_pkg::cswgp_state_t   state;
    cswgp_pkg::cswgp_state_t   next_state;
    logic [cswgp_pkg::DEB_W-1:0] deb_cnt;
    logic [cswgp_pkg::DEB_W-1:0] next_deb_cnt;
    logic                      cs_a;
    logic                      cs_b;
    logic                      wipe;
    logic                      next_flag;
    logic                      next_lv_level;
    cswgp_pkg::cswgp_pin_cfg_t cfg [PINS];
    cswgp_pkg::cswgp_pin_cfg_t next_cfg [PINS];
    logic [PINS-1:0]           cell_out;
    logic [PINS-1:0]           cell_oe;

    function automatic cswgp_pkg::cswgp_pin_cfg_t reset_cfg(input int idx);
        return (idx < cswgp_pkg::HV_PIN_COUNT) ? cswgp_pkg::CFG_RESET_HV
                                               : cswgp_pkg::CFG_RESET_LV;
    endfunction

    // chip-select is a pin: two flops before use
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_a <= 1'b0;
            cs_b <= 1'b0;
        end else begin
            cs_a <= chip_select;
            cs_b <= cs_a;
        end
    end

    always_comb begin
        next_state   = state;
        next_deb_cnt = deb_cnt;
        unique case (state)
            cswgp_pkg::ST_LOW_IQ: begin
                if (cs_b) begin
                    next_state = cswgp_pkg::ST_ACTIVE;
                end
            end
            cswgp_pkg::ST_ACTIVE: begin
                if (!cs_b) begin
                    if (select_release_debounce_time == '0) begin
                        next_state = cswgp_pkg::ST_LOW_IQ;
                    end else begin
                        next_state   = cswgp_pkg::ST_DEBNC;
                        next_deb_cnt = select_release_debounce_time;
                    end
                end
            end
            cswgp_pkg::ST_DEBNC: begin
                if (cs_b) begin
                    next_state = cswgp_pkg::ST_ACTIVE;
                end else if (deb_cnt == 13'h0001) begin
                    next_state = cswgp_pkg::ST_LOW_IQ;
                end else begin
                    next_deb_cnt = deb_cnt - 13'h0001;
                end
            end
            default: begin
                next_state = cswgp_pkg::ST_LOW_IQ;
            end
        endcase
        if (next_state == cswgp_pkg::ST_LOW_IQ) begin
            next_deb_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state   <= cswgp_pkg::ST_LOW_IQ;
            deb_cnt <= '0;
        end else begin
            state   <= next_state;
            deb_cnt <= next_deb_cnt;
        end
    end

    // low-IQ state wipes the flag, the low-voltage level and every pin configuration each cycle
    assign wipe = (state == cswgp_pkg::ST_LOW_IQ);

    always_comb begin
        next_flag     = config_integrity_flag;
        next_lv_level = lv_input_level;
        for (int i = 0; i < PINS; i++) begin
            next_cfg[i] = cfg[i];
            if (cfg_write && (int'(cfg_index) == i)) begin
                next_cfg[i] = cfg_data;
            end
        end
        if (lv_level_write) begin
            next_lv_level = lv_level_data;
        end
        if (flag_set) begin
            next_flag = 1'b1;
        end
        // reset-type events beat a simultaneous software set
        if (|reset_events || next_state != cswgp_pkg::ST_ACTIVE) begin
            next_flag = 1'b0;
        end
        if (wipe) begin
            next_flag     = 1'b0;
            next_lv_level = cswgp_pkg::LEVEL_1V2;
            for (int i = 0; i < PINS; i++) begin
                next_cfg[i] = reset_cfg(i);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            config_integrity_flag <= 1'b0;
            lv_input_level        <= cswgp_pkg::LEVEL_1V2;
            for (int i = 0; i < PINS; i++) begin
                cfg[i] <= reset_cfg(i);
            end
        end else begin
            config_integrity_flag <= next_flag;
            lv_input_level        <= next_lv_level;
            for (int i = 0; i < PINS; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            cswgp_pin_cell #(
                .HIGH_VOLTAGE   (g < cswgp_pkg::HV_PIN_COUNT),
                .OUTPUT_ALLOWED (g < PINS - 1)
            ) u_cell (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .cfg       (cfg[g]),
                .pin_in    (pin_in[g]),
                .pin_out   (cell_out[g]),
                .pin_oe    (cell_oe[g]),
                .pin_value (pin_value[g])
            );
            assign pin_pull_down[g] = cfg[g].pull_down & (g < cswgp_pkg::HV_PIN_COUNT);
            if (g < cswgp_pkg::HV_PIN_COUNT) begin : g_hv
                assign hv_input_mode[g] = cfg[g].in_mode;
            end
        end
    endgenerate

    // pin five alternate: data line, only ever pulls low
    always_comb begin
        pin_out = cell_out;
        pin_oe  = cell_oe;
        if (cfg[4].alt_func) begin
            pin_out[4] = 1'b0;
            pin_oe[4]  = i2c_data_pull_low & ~wipe;
        end
        pin_oe[5]  = 1'b0;
        pin_out[5] = 1'b0;
    end

    always_comb begin
        for (int i = 0; i < cswgp_pkg::HV_PIN_COUNT; i++) begin
            target_addr_bits[i] = cfg[i].alt_func & pin_value[i];
        end
    end

    assign i2c_data_in    = pin_value[4];
    assign i2c_clock_in   = pin_value[5];
    assign awake          = ~wipe;
    assign logic_shutdown = wipe;
endmodule

// [sim/cswgp_assertions.sv]
// checker: port-level properties of the wake and pin block
`timescale 1ns/1ns
module cswgp_assertions #(
    parameter int PINS = 6
) (
    input wire logic                           clk_sys,
    input wire logic                           rst,
    input wire logic                           chip_select,
    input wire cswgp_pkg::cswgp_reset_events_t reset_events,
    input wire logic                           awake,
    input wire logic                           config_integrity_flag,
    input wire logic [PINS-1:0]                pin_out,
    input wire logic [PINS-1:0]                pin_oe,
    input wire logic [PINS-1:0]                pin_pull_down
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_wake; !awake && $rose(chip_select) ##1 chip_select [*2] |=> awake; endproperty
    a_wake: assert property (p_wake) else $error("no wake after select");
    property p_evt; |reset_events |=> !config_integrity_flag; endproperty
    a_evt: assert property (p_evt) else $error("flag survived event");
    property p_sleep; !awake |=> !config_integrity_flag; endproperty
    a_sleep: assert property (p_sleep) else $error("flag set while asleep");
    property p_pin6; !pin_oe[5]; endproperty
    a_pin6: assert property (p_pin6) else $error("pin six drives");
    property p_lvpd; pin_pull_down[5:4] == 2'h0; endproperty
    a_lvpd: assert property (p_lvpd) else $error("low-voltage pin pulled");
    property p_rst_oe; !awake [*3] |-> pin_oe == '0; endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("driver on while asleep");
    property p_rst_pd; !awake [*3] |-> pin_pull_down[3:0] == 4'hf; endproperty
    a_rst_pd: assert property (p_rst_pd) else $error("pull-down off asleep");
    property p_od5; pin_oe[4] |-> !pin_out[4]; endproperty
    a_od5: assert property (p_od5) else $error("pin five drives high");
endmodule

bind cswgp_top cswgp_assertions #(.PINS(PINS)) cswgp_assertions_i (.clk_sys(clk_sys),
    .rst(rst), .chip_select(chip_select), .reset_events(reset_events), .awake(awake),
    .config_integrity_flag(config_integrity_flag), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_down(pin_pull_down));

// [sim/cswgp_host_model.sv]
// host model: chip-select driver and resolved pin lines
`timescale 1ns/1ns
module cswgp_host_model (
    input  wire logic       cs_req,
    input  wire logic       supply_ok,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pin_pull_down,
    input  wire logic [5:0] ext_val,
    output logic            chip_select,
    output logic [5:0]      pin_in
);
    assign chip_select = cs_req & supply_ok;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pull_down[i] ? 1'b0 : ext_val[i]);
        end
        // data line: pull-up, and either side may pull it low
        pin_in[4] = ext_val[4] & !(pin_oe[4] && !pin_out[4]);
    end
endmodule

// [sim/cswgp_top_tb.sv]
// testbench: wake, debounce, integrity flag and pin configuration
`timescale 1ns/1ns
module cswgp_top_tb;
    logic                           clk_sys = 1'b0, rst = 1'b1, cs_req = 1'b0;
    logic                           supply_ok = 1'b0, flag_set = 1'b0, cfg_write = 1'b0;
    logic                           lv_write = 1'b0, lv_data = 1'b0, sda_low = 1'b0;
    logic                           chip_select, awake, shutdown, flag, lv_level, i2c_d, i2c_c;
    logic [2:0]                     cfg_index = '0;
    logic [3:0]                     addr;
    logic [5:0]                     ext_val = '0, pin_in, pin_out, pin_oe, pin_pd, pin_value;
    logic [1:0]                     e, hv_mode [4];
    logic [cswgp_pkg::DEB_W-1:0]    deb = '0;
    logic [31:0]                    seed = 32'h0000_0b83;
    cswgp_pkg::cswgp_reset_events_t evt = '0;
    cswgp_pkg::cswgp_pin_cfg_t      cfg_data = '0, c;
    int                             fail_count = 0, checked = 0, n;
    always #20 clk_sys = ~clk_sys;
    cswgp_top cswgp_top_i (.clk_sys(clk_sys), .rst(rst), .chip_select(chip_select),
        .select_release_debounce_time(deb), .reset_events(evt), .flag_set(flag_set),
        .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_data(cfg_data),
        .lv_level_write(lv_write), .lv_level_data(lv_data), .i2c_data_pull_low(sda_low),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_down(pin_pd),
        .hv_input_mode(hv_mode), .lv_input_level(lv_level), .pin_value(pin_value),
        .awake(awake), .logic_shutdown(shutdown), .config_integrity_flag(flag),
        .target_addr_bits(addr), .i2c_data_in(i2c_d), .i2c_clock_in(i2c_c));
    cswgp_host_model cswgp_host_model_i (.cs_req(cs_req), .supply_ok(supply_ok),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_down(pin_pd), .ext_val(ext_val),
        .chip_select(chip_select), .pin_in(pin_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected {enable, driven level}, level masked when not driving
    function automatic logic [1:0] exp_drive(int p, logic [1:0] m, logic v);
        if (p == 5 || m == cswgp_pkg::OUT_NONE) return 2'h0;
        if (m == cswgp_pkg::OUT_OD_LOW) return {~v, 1'b0};
        if (p == 4) return 2'h0;
        return (m == cswgp_pkg::OUT_PUSH_PULL) ? {1'b1, v} : {v, v};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic edges_until(input logic lvl, output int cnt);
        for (cnt = 0; awake !== lvl; cnt++) begin
            if (cnt > 7000) begin
                fail_count++;
                tally_and_finish();
            end
            tick(1);
        end
    endtask
    // four edges: one to take, one for the output register, two for the input synchroniser
    task automatic write_cfg(input logic [2:0] idx, input cswgp_pkg::cswgp_pin_cfg_t w);
        cfg_index = idx;
        cfg_data = w;
        cfg_write = 1'b1;
        tick(1);
        cfg_write = 1'b0;
        tick(3);
    endtask
    initial begin
        tick(6);
        rst = 1'b0;
        tick(1);
        check({awake, shutdown, flag, lv_level, pin_oe, pin_pd}, 16'h400f);
        cs_req = 1'b1;
        write_cfg(3'h0, 7'h40);
        check({awake, pin_oe}, 7'h00);
        supply_ok = 1'b1;
        edges_until(1'b1, n);
        check(n, 2'h3);
        $display("wake test done");
        for (int p = 0; p < 6; p++) begin
            for (int m = 0; m < 4; m++) begin
                c = 7'(rnd());
                c.out_mode = 2'(m);
                c.alt_func = 1'b0;
                ext_val = 6'(rnd());
                write_cfg(3'(p), c);
                e = exp_drive(p, c.out_mode, c.out_value);
                check({pin_oe[p], pin_oe[p] & pin_out[p]}, e);
                if (p < 4) check({hv_mode[p], pin_pd[p]}, {c.in_mode, c.pull_down});
                check(pin_value[p], e[1] ? e[0] : !(p < 4 && c.pull_down) & ext_val[p]);
            end
        end
        $display("pin mode test done");
        c = '0;
        c.alt_func = 1'b1;
        for (int p = 0; p < 6; p++) write_cfg(3'(p), c);
        check({addr, i2c_d, i2c_c}, {ext_val[3:0], ext_val[4], ext_val[5]});
        // controller lets go, so a low here can only come from the block
        ext_val[4] = 1'b1;
        sda_low = 1'b1;
        tick(3);
        check({pin_oe[4], pin_out[4], i2c_d}, 3'h4);
        sda_low = 1'b0;
        for (int k = 0; k < 5; k++) begin
            flag_set = 1'b1;
            tick(1);
            flag_set = 1'b0;
            check(flag, 1'b1);
            evt = 5'(1 << k);
            tick(1);
            evt = '0;
            check(flag, 1'b0);
        end
        lv_data = 1'b1;
        lv_write = 1'b1;
        flag_set = 1'b1;
        tick(1);
        {lv_write, flag_set} = 2'h0;
        check({lv_level, flag}, 2'h3);
        deb = 13'h0010;
        cs_req = 1'b0;
        tick(8);
        cs_req = 1'b1;
        tick(20);
        check({awake, lv_level, flag}, 3'h6);
        $display("flag and cancel test done");
        for (int j = 0; j < 3; j++) begin
            deb = (j == 0) ? '0 : (j == 1) ? 13'(rnd() % 50 + 1) : 13'(cswgp_pkg::DEBOUNCE_MAX_CYC);
            write_cfg(3'h0, '0);
            cs_req = 1'b0;
            edges_until(1'b0, n);
            check(n, deb + 3);
            tick(3);
            check({pin_oe, pin_pd, lv_level}, 13'h001e);
            lv_write = 1'b1;
            tick(1);
            lv_write = 1'b0;
            tick(1);
            check(lv_level, 1'b0);
            cs_req = 1'b1;
            edges_until(1'b1, n);
            check(n, 2'h3);
        end
        $display("debounce test done");
        tally_and_finish();
    end
endmodule
